// ===== io_port_pkg.sv
// constants and carrier types for the p0/p1/p2 general-purpose port block
// assumes a 32-bit axi4-lite register bus with byte addresses
`default_nettype none
package io_port_pkg;
   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_P0_LATCH     = 8'h00;
   localparam logic [7:0] IDX_P1_LATCH     = 8'h01;
   localparam logic [7:0] IDX_P2_LATCH     = 8'h02;
   localparam logic [7:0] IDX_P0_OPEN      = 8'h03;
   localparam logic [7:0] IDX_P0_DIR       = 8'h0a;
   localparam logic [7:0] IDX_P1_DIR       = 8'h0b;
   localparam logic [7:0] IDX_P0_LVIEW     = 8'h10;
   localparam logic [7:0] IDX_P1_LVIEW     = 8'h11;
   localparam logic [7:0] IDX_P2_LVIEW     = 8'h12;
   localparam logic [7:0] IDX_SYSCTL       = 8'h14;
   localparam logic [7:0] IDX_IRQ_STATUS   = 8'h15;
   localparam logic [7:0] IDX_IRQ_MASK     = 8'h16;
   localparam int         ADDR_W           = 12;

   // widths
   localparam int P0_W = 4;
   localparam int P1_W = 8;
   localparam int P2_W = 3;

   // reset values
   localparam logic [3:0] P0_LATCH_RST = 4'h0;
   localparam logic [3:0] P0_DIR_RST   = 4'h0;
   localparam logic [3:0] P0_OPEN_RST  = 4'h0;
   localparam logic [7:0] P1_LATCH_RST = 8'h00;
   localparam logic [7:0] P1_DIR_RST   = 8'h00;
   localparam logic [2:0] P2_LATCH_RST = 3'h7;
   localparam logic       HOLD_RST     = 1'b0;
   localparam logic       IRQ_RST      = 1'b0;

   // field positions
   localparam int HOLD_BIT      = 0;
   localparam int IRQ_P2B0_BIT  = 0;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_COMMIT = 2'b01,
      ST_WRESP  = 2'b10,
      ST_RRESP  = 2'b11
   } bus_state_t;

   typedef struct packed {
      logic [3:0] level;
      logic [3:0] oe_n;
   } p0_drive_t;

   typedef struct packed {
      logic [7:0] level;
      logic [7:0] oe_n;
   } p1_drive_t;

   typedef struct packed {
      logic [2:0] level;
      logic [2:0] oe_n;
   } p2_drive_t;
endpackage
`default_nettype wire

// ===== io_port.sv
// general-purpose i/o ports 0, 1 and 2 with an axi4-lite register slave
// assumes pins arrive asynchronously; stop_mode_in comes from the same clock
//
// Notes on behaviour
// - output latch holds writes; pins read live
// - pins sampled in first read state
// - latch loaded in second write state
// - read-modify-write source reads the latch
// - every other read returns pin levels
// - port 0 four bits, direction resets input
// - port 0 latch resets to zero
// - port 0 open-drain select, resets tri-state
// - open-drain bits: rmw reads latch
// - port 1 eight bits, direction resets input
// - port 1 latch read/write, resets zero
// - port 2 latch resets to ones
// - port 2 bits seven to three undefined
// - port 2 rmw reads latch, else pins
// - port 2 bit 0 falling edge interrupts
// - stop mode floats port 2 bit 0
//
// The AXI4-Lite slave port was left to the implementer.
`default_nettype none
module io_port (
   input  wire logic                          ref_clk_in,
   input  wire logic                          reset_n_in,
   // axi4-lite slave
   input  wire logic [io_port_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic                          s_axi_awvalid_in,
   output logic                               s_axi_awready_out,
   input  wire logic [31:0]                   s_axi_wdata_in,
   input  wire logic [3:0]                    s_axi_wstrb_in,
   input  wire logic                          s_axi_wvalid_in,
   output logic                               s_axi_wready_out,
   output logic [1:0]                         s_axi_bresp_out,
   output logic                               s_axi_bvalid_out,
   input  wire logic                          s_axi_bready_in,
   input  wire logic [io_port_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic                          s_axi_arvalid_in,
   output logic                               s_axi_arready_out,
   output logic [31:0]                        s_axi_rdata_out,
   output logic [1:0]                         s_axi_rresp_out,
   output logic                               s_axi_rvalid_out,
   input  wire logic                          s_axi_rready_in,
   // pins
   input  wire logic [3:0]                    port0_pins_in,
   output io_port_pkg::p0_drive_t             port0_pins_out,
   input  wire logic [7:0]                    port1_pins_in,
   output io_port_pkg::p1_drive_t             port1_pins_out,
   input  wire logic [2:0]                    port2_pins_in,
   output io_port_pkg::p2_drive_t             port2_pins_out,
   // system
   input  wire logic                          stop_mode_in,
   output logic                               irq_out
);

   localparam int PIN_W = io_port_pkg::P0_W + io_port_pkg::P1_W + io_port_pkg::P2_W;

   // pin synchronisers
   logic [PIN_W-1:0] pin_meta_q;
   logic [PIN_W-1:0] pin_sync_q;
   logic             p2b0_prev_q;

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= {port2_pins_in, port1_pins_in, port0_pins_in};
         pin_sync_q <= pin_meta_q;
      end
   end

   // starts low like the synchroniser: no false fall
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         p2b0_prev_q <= 1'b0;
      end else begin
         p2b0_prev_q <= pin_sync_q[12];
      end
   end

   wire logic [3:0] p0_pin_lvl = pin_sync_q[3:0];
   wire logic [7:0] p1_pin_lvl = pin_sync_q[11:4];
   wire logic [2:0] p2_pin_lvl = pin_sync_q[14:12];

   // port registers
   logic [3:0] port0_output_latch_q;
   logic [3:0] port0_direction_q;
   logic [3:0] port0_open_drain_select_q;
   logic [7:0] port1_output_latch_q;
   logic [7:0] port1_direction_q;
   logic [2:0] port2_output_latch_q;
   logic       output_hold_enable_q;
   logic [0:0] irq_status_q;
   logic [0:0] irq_mask_q;

   localparam logic [0:0] IRQ_RST_V = io_port_pkg::IRQ_RST;

   // bus state
   io_port_pkg::bus_state_t state_q;
   io_port_pkg::bus_state_t state_d;
   logic                    aw_held_q;
   logic                    w_held_q;
   logic [7:0]              waddr_idx_q;
   logic [7:0]              wdata_q;
   logic                    wstrb_q;
   logic [31:0]             rdata_q;
   logic [1:0]              rresp_q;
   logic [1:0]              bresp_q;

   wire logic is_idle   = (state_q == io_port_pkg::ST_IDLE);
   wire logic aw_take   = s_axi_awvalid_in && s_axi_awready_out;
   wire logic w_take    = s_axi_wvalid_in && s_axi_wready_out;
   wire logic ar_take   = s_axi_arvalid_in && s_axi_arready_out;
   wire logic aw_have   = aw_held_q || aw_take;
   wire logic w_have    = w_held_q || w_take;
   wire logic both_have = is_idle && aw_have && w_have;

   assign s_axi_awready_out = is_idle && !aw_held_q;
   assign s_axi_wready_out  = is_idle && !w_held_q;
   assign s_axi_arready_out = is_idle && !aw_held_q && !w_held_q && !s_axi_awvalid_in
                              && !s_axi_wvalid_in;

   // address decode, index = byte address / 4
   wire logic [7:0] aw_idx  = 8'(s_axi_awaddr_in[io_port_pkg::ADDR_W-1:2]);
   wire logic [7:0] ar_idx  = 8'(s_axi_araddr_in[io_port_pkg::ADDR_W-1:2]);
   wire logic       commit  = (state_q == io_port_pkg::ST_COMMIT);
   wire logic       wr_en   = commit && wstrb_q;
   wire logic       hit_p0  = wr_en && ((waddr_idx_q == io_port_pkg::IDX_P0_LATCH)
                                     || (waddr_idx_q == io_port_pkg::IDX_P0_LVIEW));
   wire logic       hit_p1  = wr_en && ((waddr_idx_q == io_port_pkg::IDX_P1_LATCH)
                                     || (waddr_idx_q == io_port_pkg::IDX_P1_LVIEW));
   wire logic       hit_p2  = wr_en && ((waddr_idx_q == io_port_pkg::IDX_P2_LATCH)
                                     || (waddr_idx_q == io_port_pkg::IDX_P2_LVIEW));
   wire logic       hit_p0o = wr_en && (waddr_idx_q == io_port_pkg::IDX_P0_OPEN);
   wire logic       hit_p0d = wr_en && (waddr_idx_q == io_port_pkg::IDX_P0_DIR);
   wire logic       hit_p1d = wr_en && (waddr_idx_q == io_port_pkg::IDX_P1_DIR);
   wire logic       hit_sys = wr_en && (waddr_idx_q == io_port_pkg::IDX_SYSCTL);
   wire logic       hit_ist = wr_en && (waddr_idx_q == io_port_pkg::IDX_IRQ_STATUS);
   wire logic       hit_imk = wr_en && (waddr_idx_q == io_port_pkg::IDX_IRQ_MASK);

   function automatic logic idx_mapped(input logic [7:0] idx);
      begin
         case (idx)
            io_port_pkg::IDX_P0_LATCH, io_port_pkg::IDX_P1_LATCH,
            io_port_pkg::IDX_P2_LATCH, io_port_pkg::IDX_P0_OPEN,
            io_port_pkg::IDX_P0_DIR, io_port_pkg::IDX_P1_DIR,
            io_port_pkg::IDX_P0_LVIEW, io_port_pkg::IDX_P1_LVIEW,
            io_port_pkg::IDX_P2_LVIEW, io_port_pkg::IDX_SYSCTL,
            io_port_pkg::IDX_IRQ_STATUS, io_port_pkg::IDX_IRQ_MASK: idx_mapped = 1'b1;
            default: begin
               idx_mapped = 1'b0;
            end
         endcase
      end
   endfunction

   // read mux; pin view samples live levels at the address handshake
   logic [7:0] rd_byte;
   always_comb begin
      case (ar_idx)
         io_port_pkg::IDX_P0_LATCH:   rd_byte = {4'h0, p0_pin_lvl};
         io_port_pkg::IDX_P1_LATCH:   rd_byte = p1_pin_lvl;
         io_port_pkg::IDX_P2_LATCH:   rd_byte = {5'h00, p2_pin_lvl};
         io_port_pkg::IDX_P0_LVIEW:   rd_byte = {4'h0, port0_output_latch_q};
         io_port_pkg::IDX_P1_LVIEW:   rd_byte = port1_output_latch_q;
         io_port_pkg::IDX_P2_LVIEW:   rd_byte = {5'h00, port2_output_latch_q};
         io_port_pkg::IDX_P0_OPEN:    rd_byte = {4'h0, port0_open_drain_select_q};
         io_port_pkg::IDX_P0_DIR:     rd_byte = {4'h0, port0_direction_q};
         io_port_pkg::IDX_P1_DIR:     rd_byte = port1_direction_q;
         io_port_pkg::IDX_SYSCTL:     rd_byte = {7'h00, output_hold_enable_q};
         io_port_pkg::IDX_IRQ_STATUS: rd_byte = {7'h00, irq_status_q};
         io_port_pkg::IDX_IRQ_MASK:   rd_byte = {7'h00, irq_mask_q};
         default:                     rd_byte = 8'h00;
      endcase
   end

   // bus sequencing
   always_comb begin
      case (state_q)
         io_port_pkg::ST_IDLE: begin
            if (both_have) begin
               state_d = io_port_pkg::ST_COMMIT;
            end else if (ar_take) begin
               state_d = io_port_pkg::ST_RRESP;
            end else begin
               state_d = io_port_pkg::ST_IDLE;
            end
         end
         io_port_pkg::ST_COMMIT: begin
            state_d = io_port_pkg::ST_WRESP;
         end
         io_port_pkg::ST_WRESP: begin
            state_d = s_axi_bready_in ? io_port_pkg::ST_IDLE : io_port_pkg::ST_WRESP;
         end
         io_port_pkg::ST_RRESP: begin
            state_d = s_axi_rready_in ? io_port_pkg::ST_IDLE : io_port_pkg::ST_RRESP;
         end
         default: begin
            state_d = io_port_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= io_port_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // address and data capture; both may arrive in either order
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         aw_held_q   <= 1'b0;
         w_held_q    <= 1'b0;
         waddr_idx_q <= 8'h00;
         wdata_q     <= 8'h00;
         wstrb_q     <= 1'b0;
      end else begin
         if (aw_take) begin
            waddr_idx_q <= aw_idx;
         end
         if (w_take) begin
            wdata_q <= s_axi_wdata_in[7:0];
            wstrb_q <= s_axi_wstrb_in[0];
         end
         aw_held_q <= both_have ? 1'b0 : aw_have;
         w_held_q  <= both_have ? 1'b0 : w_have;
      end
   end

   // responses
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_q <= 32'h0000_0000;
         rresp_q <= io_port_pkg::RESP_OKAY;
         bresp_q <= io_port_pkg::RESP_OKAY;
      end else begin
         if (ar_take) begin
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= idx_mapped(ar_idx) ? io_port_pkg::RESP_OKAY
                                          : io_port_pkg::RESP_SLVERR;
         end
         if (commit) begin
            bresp_q <= idx_mapped(waddr_idx_q) ? io_port_pkg::RESP_OKAY
                                               : io_port_pkg::RESP_SLVERR;
         end
      end
   end

   assign s_axi_rdata_out  = rdata_q;
   assign s_axi_rresp_out  = rresp_q;
   assign s_axi_rvalid_out = (state_q == io_port_pkg::ST_RRESP);
   assign s_axi_bresp_out  = bresp_q;
   assign s_axi_bvalid_out = (state_q == io_port_pkg::ST_WRESP);

   // latch and control registers, loaded in the commit state
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port0_output_latch_q      <= io_port_pkg::P0_LATCH_RST;
         port0_direction_q         <= io_port_pkg::P0_DIR_RST;
         port0_open_drain_select_q <= io_port_pkg::P0_OPEN_RST;
         port1_output_latch_q      <= io_port_pkg::P1_LATCH_RST;
         port1_direction_q         <= io_port_pkg::P1_DIR_RST;
         port2_output_latch_q      <= io_port_pkg::P2_LATCH_RST;
         output_hold_enable_q      <= io_port_pkg::HOLD_RST;
         irq_mask_q                <= IRQ_RST_V;
      end else begin
         if (hit_p0) begin
            port0_output_latch_q <= wdata_q[3:0];
         end
         if (hit_p1) begin
            port1_output_latch_q <= wdata_q;
         end
         if (hit_p2) begin
            port2_output_latch_q <= wdata_q[2:0];
         end
         if (hit_p0o) begin
            port0_open_drain_select_q <= wdata_q[3:0];
         end
         if (hit_p0d) begin
            port0_direction_q <= wdata_q[3:0];
         end
         if (hit_p1d) begin
            port1_direction_q <= wdata_q;
         end
         if (hit_sys) begin
            output_hold_enable_q <= wdata_q[io_port_pkg::HOLD_BIT];
         end
         if (hit_imk) begin
            irq_mask_q <= wdata_q[io_port_pkg::IRQ_P2B0_BIT];
         end
      end
   end

   // external interrupt latch; a new edge wins over a clear
   wire logic p2b0_fall = p2b0_prev_q && !pin_sync_q[12];
   wire logic irq_clear = hit_ist && wdata_q[io_port_pkg::IRQ_P2B0_BIT];

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_status_q <= IRQ_RST_V;
      end else if (p2b0_fall) begin
         irq_status_q <= 1'b1;
      end else if (irq_clear) begin
         irq_status_q <= 1'b0;
      end
   end

   assign irq_out = |(irq_status_q & irq_mask_q);

   // pin drivers; stop without hold floats everything
   wire logic float_all = stop_mode_in && !output_hold_enable_q;

   logic [3:0] p0_lvl_d;
   logic [3:0] p0_oe_n_d;
   logic [7:0] p1_oe_n_d;
   logic [2:0] p2_oe_n_d;

   always_comb begin
      for (int i = 0; i < io_port_pkg::P0_W; i++) begin
         if (float_all || !port0_direction_q[i]) begin
            p0_oe_n_d[i] = 1'b1;
            p0_lvl_d[i]  = 1'b0;
         end else if (port0_open_drain_select_q[i]) begin
            p0_oe_n_d[i] = port0_output_latch_q[i];
            p0_lvl_d[i]  = 1'b0;
         end else begin
            p0_oe_n_d[i] = 1'b0;
            p0_lvl_d[i]  = port0_output_latch_q[i];
         end
      end
   end

   always_comb begin
      p1_oe_n_d = float_all ? 8'hff : ~port1_direction_q;
      // port 2 pulls low only; latch one leaves the pin free as an input
      p2_oe_n_d = float_all ? 3'h7 : port2_output_latch_q;
      if (stop_mode_in) begin
         p2_oe_n_d[0] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port0_pins_out <= '{level: 4'h0, oe_n: 4'hf};
      end else begin
         port0_pins_out <= '{level: p0_lvl_d, oe_n: p0_oe_n_d};
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port1_pins_out <= '{level: 8'h00, oe_n: 8'hff};
      end else begin
         port1_pins_out <= '{level: port1_output_latch_q, oe_n: p1_oe_n_d};
      end
   end

   // port 2 only ever pulls low
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port2_pins_out <= '{level: 3'h0, oe_n: 3'h7};
      end else begin
         port2_pins_out <= '{level: 3'h0, oe_n: p2_oe_n_d};
      end
   end

endmodule
`default_nettype wire

// ===== io_port_sva.sv
// concurrent checks on the io_port top-level ports
// assumes one clock domain with an async active-low reset
`default_nettype none
module io_port_sva (
   input wire logic                   ref_clk_in,
   input wire logic                   reset_n_in,
   input wire logic                   s_axi_awvalid_in,
   input wire logic                   s_axi_awready_out,
   input wire logic                   s_axi_wvalid_in,
   input wire logic                   s_axi_wready_out,
   input wire logic                   s_axi_bvalid_out,
   input wire logic                   s_axi_bready_in,
   input wire logic                   s_axi_arvalid_in,
   input wire logic                   s_axi_arready_out,
   input wire logic [31:0]            s_axi_rdata_out,
   input wire logic                   s_axi_rvalid_out,
   input wire logic                   s_axi_rready_in,
   input wire io_port_pkg::p0_drive_t port0_pins_out,
   input wire io_port_pkg::p2_drive_t port2_pins_out,
   input wire logic                   stop_mode_in,
   input wire logic                   irq_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   chk_reset_float: assert property (
      $rose(reset_n_in) |-> port0_pins_out.oe_n == 4'hf && port2_pins_out.oe_n == 3'h7)
      else $error("pins driven after reset");
   chk_p2_pull_low: assert property (
      port2_pins_out.level == 3'h0) else $error("port2 drives high");
   chk_stop_float: assert property (
      stop_mode_in |=> port2_pins_out.oe_n[0]) else $error("port2 bit0 driven in stop");
   chk_read_sample: assert property (
      s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   chk_write_commit: assert property (
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |=> !s_axi_awready_out && !s_axi_bvalid_out ##1 s_axi_bvalid_out)
      else $error("write commit timing");
   chk_bvalid_hold: assert property (
      s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out) else $error("bvalid dropped");
   chk_rdata_hold: assert property (
      s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data moved");
   chk_ar_behind_w: assert property (
      s_axi_awvalid_in || s_axi_wvalid_in |-> !s_axi_arready_out)
      else $error("read taken beside write");
   cover property (s_axi_bvalid_out && s_axi_bready_in);
   cover property (s_axi_rvalid_out && s_axi_rready_in);
   cover property ($rose(irq_out));
endmodule
`default_nettype wire

// ===== pin_board.sv
// board model: resolves each port pin from the block's drive and the board level
// assumes released pins settle to the level the bench sets on the board
`default_nettype none
module pin_board (
   input  wire io_port_pkg::p0_drive_t p0_drv_in,
   input  wire io_port_pkg::p1_drive_t p1_drv_in,
   input  wire io_port_pkg::p2_drive_t p2_drv_in,
   input  wire logic [3:0]             p0_ext_in,
   input  wire logic [7:0]             p1_ext_in,
   input  wire logic [2:0]             p2_ext_in,
   output logic [3:0]                  p0_pins_out,
   output logic [7:0]                  p1_pins_out,
   output logic [2:0]                  p2_pins_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // driven bits follow the block, released bits the board
   assign p0_pins_out = (p0_drv_in.level & ~p0_drv_in.oe_n) | (p0_ext_in & p0_drv_in.oe_n);
   assign p1_pins_out = (p1_drv_in.level & ~p1_drv_in.oe_n) | (p1_ext_in & p1_drv_in.oe_n);
   assign p2_pins_out = (p2_drv_in.level & ~p2_drv_in.oe_n) | (p2_ext_in & p2_drv_in.oe_n);
endmodule
`default_nettype wire

// ===== tb_top.sv
// testbench for io_port: axi4-lite master tasks, board model, directed tests
// assumes the package and the board model are compiled first
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   ref_clk = 1'b0;
   logic                   reset_n = 1'b0;
   logic [11:0]            awaddr = 12'h000;
   logic [11:0]            araddr = 12'h000;
   logic [31:0]            wdata = 32'h0;
   logic                   awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                   arvalid = 1'b0, rready = 1'b0, stop = 1'b0;
   logic                   awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]             bresp, rresp, rs;
   logic [31:0]            rdata, rd;
   logic [3:0]             p0_ext = 4'h3, p0_pins;
   logic [7:0]             p1_ext = 8'ha5, p1_pins;
   logic [2:0]             p2_ext = 3'h7, p2_pins;
   io_port_pkg::p0_drive_t p0_drv;
   io_port_pkg::p1_drive_t p1_drv;
   io_port_pkg::p2_drive_t p2_drv;
   int                     error_cnt = 0;
   int                     compares = 0;
   always #2.5 ref_clk = ~ref_clk;
   io_port i_dut (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .port0_pins_in(p0_pins), .port0_pins_out(p0_drv),
      .port1_pins_in(p1_pins), .port1_pins_out(p1_drv), .port2_pins_in(p2_pins),
      .port2_pins_out(p2_drv), .stop_mode_in(stop), .irq_out(irq));
   pin_board i_board (.p0_drv_in(p0_drv), .p1_drv_in(p1_drv), .p2_drv_in(p2_drv),
      .p0_ext_in(p0_ext), .p1_ext_in(p1_ext), .p2_ext_in(p2_ext),
      .p0_pins_out(p0_pins), .p1_pins_out(p1_pins), .p2_pins_out(p2_pins));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ready levels are taken at the falling edge, equal to the next rising edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      logic t_aw, t_w, t_b, t_end;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      forever begin
         @(negedge ref_clk);
         t_aw = awvalid && awready;
         t_w = wvalid && wready;
         t_b = bvalid;
         t_end = bvalid && bready;
         r = bresp;
         @(posedge ref_clk);
         if (t_aw) awvalid <= 1'b0;
         if (t_w) wvalid <= 1'b0;
         bready <= t_b && !t_end;
         if (t_end) break;
      end
   endtask
   task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic t_a, t_r, t_end;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      forever begin
         @(negedge ref_clk);
         t_a = arvalid && arready;
         t_r = rvalid;
         t_end = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge ref_clk);
         if (t_a) arvalid <= 1'b0;
         rready <= t_r && !t_end;
         if (t_end) break;
      end
   endtask
   task automatic wok(input logic [7:0] i, input logic [7:0] d);
      logic [1:0] r;
      wr({2'b00, i, 2'b00}, d, r);
      chk_resp("write resp", io_port_pkg::RESP_OKAY, r);
   endtask
   task automatic rchk(input string what, input logic [7:0] i, input logic [7:0] exp);
      rd_reg({2'b00, i, 2'b00}, rd, rs);
      chk(what, {24'h0, exp}, rd);
      chk_resp(what, io_port_pkg::RESP_OKAY, rs);
   endtask
   // pin sync and output register settle, then look between edges
   task automatic settle();
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic results();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      rchk("p0 dir", io_port_pkg::IDX_P0_DIR, 8'h00);
      rchk("p0 open", io_port_pkg::IDX_P0_OPEN, 8'h00);
      rchk("p1 dir", io_port_pkg::IDX_P1_DIR, 8'h00);
      rchk("p0 latch", io_port_pkg::IDX_P0_LVIEW, 8'h00);
      rchk("p1 latch", io_port_pkg::IDX_P1_LVIEW, 8'h00);
      rchk("p2 latch", io_port_pkg::IDX_P2_LVIEW, 8'h07);
      rchk("irq status", io_port_pkg::IDX_IRQ_STATUS, 8'h00);
      chk("p1 oe_n", 32'hff, {24'h0, p1_drv.oe_n});
      rchk("p1 pins", io_port_pkg::IDX_P1_LATCH, 8'ha5);
      p1_ext <= 8'h3c;
      settle();
      rchk("p1 pins", io_port_pkg::IDX_P1_LATCH, 8'h3c);
      wok(io_port_pkg::IDX_P1_LATCH, 8'h5a);
      rchk("p1 latch", io_port_pkg::IDX_P1_LVIEW, 8'h5a);
      rchk("p1 pins", io_port_pkg::IDX_P1_LATCH, 8'h3c);
      wok(io_port_pkg::IDX_P1_DIR, 8'h0f);
      settle();
      chk("p1 oe_n", 32'hf0, {24'h0, p1_drv.oe_n});
      chk("p1 level", 32'h5a, {24'h0, p1_drv.level});
      rchk("p1 pins", io_port_pkg::IDX_P1_LATCH, 8'h3a);
      wok(io_port_pkg::IDX_P0_LATCH, 8'h05);
      wok(io_port_pkg::IDX_P0_DIR, 8'h0f);
      wok(io_port_pkg::IDX_P0_OPEN, 8'h0f);
      settle();
      chk("p0 oe_n", 32'h5, {28'h0, p0_drv.oe_n});
      rchk("p0 latch", io_port_pkg::IDX_P0_LVIEW, 8'h05);
      rchk("p0 pins", io_port_pkg::IDX_P0_LATCH, 8'h01);
      wok(io_port_pkg::IDX_P0_OPEN, 8'h00);
      settle();
      rchk("p0 pins", io_port_pkg::IDX_P0_LATCH, 8'h05);
      rchk("p2 pins", io_port_pkg::IDX_P2_LATCH, 8'h07);
      wok(io_port_pkg::IDX_IRQ_MASK, 8'h01);
      p2_ext <= 3'h6;
      settle();
      chk("irq", 32'h1, {31'h0, irq});
      rchk("p2 pins", io_port_pkg::IDX_P2_LATCH, 8'h06);
      rchk("p2 latch", io_port_pkg::IDX_P2_LVIEW, 8'h07);
      wok(io_port_pkg::IDX_IRQ_STATUS, 8'h01);
      p2_ext <= 3'h7;
      settle();
      chk("irq", 32'h0, {31'h0, irq});
      wok(io_port_pkg::IDX_P2_LVIEW, 8'h06);
      settle();
      chk("irq", 32'h1, {31'h0, irq});
      rchk("irq status", io_port_pkg::IDX_IRQ_STATUS, 8'h01);
      wok(io_port_pkg::IDX_IRQ_STATUS, 8'h01);
      wok(io_port_pkg::IDX_IRQ_MASK, 8'h00);
      wok(io_port_pkg::IDX_P2_LVIEW, 8'h07);
      wok(io_port_pkg::IDX_P2_LVIEW, 8'h06);
      settle();
      rchk("irq status", io_port_pkg::IDX_IRQ_STATUS, 8'h01);
      chk("irq masked", 32'h0, {31'h0, irq});
      chk("p2 oe_n", 32'h6, {29'h0, p2_drv.oe_n});
      wok(io_port_pkg::IDX_SYSCTL, 8'h01);
      stop <= 1'b1;
      settle();
      chk("p2 oe_n", 32'h7, {29'h0, p2_drv.oe_n});
      rchk("sysctl", io_port_pkg::IDX_SYSCTL, 8'h01);
      stop <= 1'b0;
      settle();
      chk("p2 oe_n", 32'h6, {29'h0, p2_drv.oe_n});
      wok(io_port_pkg::IDX_SYSCTL, 8'h00);
      stop <= 1'b1;
      settle();
      chk("p1 oe_n stop", 32'hff, {24'h0, p1_drv.oe_n});
      stop <= 1'b0;
      wr(12'h3fc, 8'h11, rs);
      chk_resp("unmapped wr", io_port_pkg::RESP_SLVERR, rs);
      rd_reg(12'h3fc, rd, rs);
      chk_resp("unmapped rd", io_port_pkg::RESP_SLVERR, rs);
      chk("unmapped rd", 32'h0, rd);
      results();
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      error_cnt++;
      results();
   end
endmodule
bind io_port io_port_sva i_sva (.ref_clk_in, .reset_n_in, .s_axi_awvalid_in,
   .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out,
   .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
   .s_axi_rvalid_out, .s_axi_rready_in, .port0_pins_out, .port2_pins_out,
   .stop_mode_in, .irq_out);
`default_nettype wire
